// ==== logic/rcw_reset_ctrl.sv ====
// reset pin control, watchdog supervision and reset effects
`timescale 1ns/1ps
`default_nettype none

module rcw_reset_ctrl
    import rcw_pkg::*;
#(
    parameter logic WATCHDOG_ENABLE_BIT_OPT     = 1'b0,
    parameter logic WAIT_RUN_OPT = 1'b1
) (
    input  wire logic        CLK,
    input  wire logic        RESETN,
    input  wire logic        RESET_PIN_I,
    output logic             RESET_PIN_O,
    output logic             RESET_PIN_OE,
    input  wire logic        TIMER_CARRY7,
    input  wire logic        STOP_EXEC,
    input  wire logic        WAIT_ENTER,
    input  wire logic        WAIT_EXIT,
    input  wire logic [1:0]  REG_ADDR,
    input  wire logic [7:0]  REG_WDATA,
    input  wire logic        REG_WR,
    input  wire logic        REG_RD,
    output logic      [7:0]  REG_RDATA,
    output logic             CORE_RESET,
    output logic             PERIPH_INIT,
    output logic             IMASK_SET,
    output logic             IMASK_CLR,
    output logic             OSC_HOLD,
    output logic             CLOCKS_CLEAR,
    output logic             ADC_DISABLE,
    output logic      [15:0] TIMER_LOAD_VAL,
    output logic      [15:0] STACK_INIT,
    output logic      [15:0] RESET_VECTOR
);

    // *****************************************************
    // declarations
    // *****************************************************
    rcw_state_e  st_reg;
    rcw_state_e  st_next;
    logic        pin_s1_reg;
    logic        pin_s2_reg;
    logic [1:0]  low_cnt_reg;
    logic        ext_req;
    logic [11:0] tmr_reg;
    logic        en_reg;
    logic        halt_reg;
    logic        por_flag_reg;
    logic        wd_cause_reg;
    logic        imask_clr_reg;
    logic [7:0]  rdata_reg;
    logic        ctrl_wr;
    logic        in_run;
    logic        pre_tick;

    rcw_watchdog_enable_bit_if wd_if ();

    assign in_run  = (st_reg == ST_RUN);
    assign ctrl_wr = REG_WR && (REG_ADDR == OFS_CTRL);

    // *****************************************************
    // reset pin synchroniser and low filter
    // *****************************************************
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            pin_s1_reg <= 1'b0;
            pin_s2_reg <= 1'b0;
        end else begin
            pin_s1_reg <= RESET_PIN_I;
            pin_s2_reg <= pin_s1_reg;
        end
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            low_cnt_reg <= 2'h0;
        end else if (pin_s2_reg) begin
            low_cnt_reg <= 2'h0;
        end else if (low_cnt_reg != 2'(RST_MIN_CYC - 1)) begin
            low_cnt_reg <= low_cnt_reg + 2'h1;
        end
    end

    // low for the minimum number of cycles
    assign ext_req = !pin_s2_reg && (low_cnt_reg == 2'(RST_MIN_CYC - 1));

    // *****************************************************
    // state machine
    // *****************************************************
    always_comb begin
        st_next = st_reg;
        case (st_reg)
            ST_POR: begin
                if (tmr_reg == 12'(OSC_HOLD_CYC - 1)) begin
                    st_next = ST_EXT;
                end
            end
            ST_RUN: begin
                if (ext_req) begin
                    st_next = ST_EXT;
                end else if (wd_if.timeout || (STOP_EXEC && en_reg)) begin
                    st_next = ST_WDRST;
                end else if (STOP_EXEC) begin
                    st_next = ST_STOP;
                end
            end
            ST_WDRST: begin
                if (!pin_s2_reg && tmr_reg == 12'(WATCHDOG_ENABLE_BIT_HOLD_CYC - 1)) begin
                    st_next = ST_EXT;
                end
            end
            ST_STOP: begin
                if (tmr_reg == 12'(OSC_HOLD_CYC - 1)) begin
                    st_next = ST_RUN;
                end
            end
            ST_EXT: begin
                if (pin_s2_reg) begin
                    st_next = ST_RUN;
                end
            end
            default: begin
                st_next = ST_POR;
            end
        endcase
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            st_reg <= ST_POR;
        end else begin
            st_reg <= st_next;
        end
    end

    // shared cycle counter for oscillator hold and pin hold time
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            tmr_reg <= 12'h000;
        end else if (st_next != st_reg) begin
            tmr_reg <= 12'h000;
        end else if (st_reg == ST_POR || st_reg == ST_STOP) begin
            tmr_reg <= tmr_reg + 12'h001;
        end else if (st_reg == ST_WDRST) begin
            tmr_reg <= pin_s2_reg ? 12'h000 : tmr_reg + 12'h001;
        end
    end

    // *****************************************************
    // watchdog enable, wait halt and counter link
    // *****************************************************
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            en_reg <= WATCHDOG_ENABLE_BIT_OPT;
        end else if (!in_run) begin
            en_reg <= WATCHDOG_ENABLE_BIT_OPT;
        end else if (ctrl_wr && REG_WDATA[CTRL_EN]) begin
            en_reg <= 1'b1;
        end
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            halt_reg <= 1'b0;
        end else if (!in_run || WAIT_EXIT) begin
            halt_reg <= 1'b0;
        end else if (WAIT_ENTER && !WAIT_RUN_OPT) begin
            halt_reg <= 1'b1;
        end
    end

    assign wd_if.clear = (ctrl_wr && REG_WDATA[CTRL_EN]) || WAIT_ENTER;
    assign wd_if.run   = en_reg && in_run && !halt_reg;
    assign wd_if.tick  = pre_tick;

    rcw_prescaler u_pre (
        .clk    (CLK),
        .resetn (RESETN),
        .clear  (!in_run),
        .carry7 (TIMER_CARRY7),
        .tick   (pre_tick)
    );

    rcw_watchdog_enable_bit_cnt u_cnt (
        .clk    (CLK),
        .resetn (RESETN),
        .wd     (wd_if)
    );

    // *****************************************************
    // flags and register port
    // *****************************************************
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            por_flag_reg <= 1'b1;
        end else if (ctrl_wr && !REG_WDATA[CTRL_POR]) begin
            por_flag_reg <= 1'b0;
        end
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            wd_cause_reg <= 1'b0;
        end else if (st_reg == ST_WDRST) begin
            wd_cause_reg <= 1'b1;
        end else if (in_run && ext_req) begin
            wd_cause_reg <= 1'b0;
        end
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            rdata_reg <= 8'h00;
        end else if (REG_RD) begin
            case (REG_ADDR)
                OFS_CTRL: rdata_reg <= {por_flag_reg, 6'h00, en_reg};
                OFS_STAT: rdata_reg <= {3'h0, wd_cause_reg, halt_reg, wd_if.count};
                default:  rdata_reg <= 8'h00;
            endcase
        end else begin
            rdata_reg <= 8'h00;
        end
    end

    assign REG_RDATA = rdata_reg;

    // *****************************************************
    // reset effects
    // *****************************************************
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            imask_clr_reg <= 1'b0;
        end else begin
            imask_clr_reg <= in_run && !ext_req && !wd_if.timeout
                             && (WAIT_ENTER || STOP_EXEC) && !(STOP_EXEC && en_reg);
        end
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            TIMER_LOAD_VAL <= TIMER_INIT_VAL;
            STACK_INIT     <= SP_INIT_VAL;
            RESET_VECTOR   <= VECTOR_ADDR;
        end else if (PERIPH_INIT) begin
            TIMER_LOAD_VAL <= TIMER_INIT_VAL;
            STACK_INIT     <= SP_INIT_VAL;
            RESET_VECTOR   <= VECTOR_ADDR;
        end
    end

    assign RESET_PIN_O  = 1'b0;
    assign RESET_PIN_OE = (st_reg == ST_POR) || (st_reg == ST_WDRST);
    assign CORE_RESET   = (st_reg == ST_POR) || (st_reg == ST_WDRST) || (st_reg == ST_EXT);
    assign PERIPH_INIT  = (st_reg == ST_POR) || (st_reg == ST_EXT);
    assign IMASK_SET    = PERIPH_INIT;
    assign IMASK_CLR    = imask_clr_reg;
    assign OSC_HOLD     = (st_reg == ST_POR) || (st_reg == ST_STOP);
    assign CLOCKS_CLEAR = OSC_HOLD;
    assign ADC_DISABLE  = PERIPH_INIT || (st_reg == ST_STOP);

    // *****************************************************
    // assertions
    // *****************************************************
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESETN);

    a_ext_entry: assert property (
        (in_run && !pin_s2_reg && $past(!pin_s2_reg) && $past(in_run)) |=> st_reg == ST_EXT)
        else $error("pin low two cycles did not reset");

    a_resume_next: assert property (
        (st_reg == ST_EXT && pin_s2_reg) |=> !CORE_RESET)
        else $error("no resume after pin high");

    a_por_drive: assert property (
        (st_reg == ST_POR) |-> (RESET_PIN_OE && !RESET_PIN_O && CORE_RESET))
        else $error("pin not driven during power-on");

    a_seven_ticks: assert property (
        $rose(wd_if.timeout) |-> ($past(wd_if.count) == 3'h6 && $past(pre_tick)))
        else $error("timeout without seventh tick");

    a_timeout_reset: assert property (
        (wd_if.timeout && in_run && !ext_req) |=> (st_reg == ST_WDRST) ##1 RESET_PIN_OE)
        else $error("timeout did not drive reset");

    a_en_sticky: assert property (
        $fell(en_reg) |-> $past(st_reg) != ST_RUN)
        else $error("watchdog disabled by software");

    a_en_write: assert property (
        (in_run && ctrl_wr && REG_WDATA[0] && !ext_req && !STOP_EXEC && !wd_if.timeout)
        |=> (en_reg && wd_if.count == 3'h0))
        else $error("write of one did not clear counter");

    a_stop_inhibit: assert property (
        (in_run && STOP_EXEC && en_reg && !ext_req) |=> (st_reg == ST_WDRST && !OSC_HOLD))
        else $error("stop not turned into watchdog reset");

    a_hold_release: assert property (
        ($past(st_reg) == ST_WDRST && st_reg == ST_EXT)
        |-> ($past(tmr_reg) == 12'(WATCHDOG_ENABLE_BIT_HOLD_CYC - 1) && !$past(pin_s2_reg)))
        else $error("pin released before hold time");

    a_osc_hold: assert property (
        $fell(OSC_HOLD) |-> $past(tmr_reg) == 12'(OSC_HOLD_CYC - 1))
        else $error("oscillator hold length wrong");

    a_wait_mask: assert property (
        (in_run && WAIT_ENTER && !STOP_EXEC && !ext_req && !wd_if.timeout) |=> IMASK_CLR)
        else $error("wait did not clear mask");

    a_stop_adc: assert property (
        (st_reg == ST_STOP) |-> (ADC_DISABLE && CLOCKS_CLEAR && !CORE_RESET))
        else $error("stop effects wrong");

    c_por_run:   cover property ($past(st_reg) == ST_EXT && in_run);
    c_wd_reset:  cover property ($rose(wd_if.timeout));
    c_stop_wake: cover property ($fell(OSC_HOLD) && in_run);
    c_wait_halt: cover property ($rose(halt_reg));

endmodule : rcw_reset_ctrl
`default_nettype wire

// ==== logic/rcw_pkg.sv ====
// constants shared by the reset and watchdog control block
package rcw_pkg;

    // *****************************************************
    // clock and timing
    // *****************************************************
    localparam int CLK_MHZ          = 20;
    localparam int CLK_PERIOD_NS    = 50;
    localparam int MCYC_NS          = 50;
    localparam int RST_MIN_MCYC_X10 = 15;
    localparam int RST_MIN_CYC      = (RST_MIN_MCYC_X10 * MCYC_NS + 10 * CLK_PERIOD_NS - 1)
                                      / (10 * CLK_PERIOD_NS);
    localparam int OSC_HOLD_CYC     = 4064;
    localparam int WATCHDOG_ENABLE_BIT_HOLD_NS     = 1000;
    localparam int WATCHDOG_ENABLE_BIT_HOLD_CYC    = (WATCHDOG_ENABLE_BIT_HOLD_NS * CLK_MHZ + 999) / 1000;

    // *****************************************************
    // watchdog chain
    // *****************************************************
    localparam logic [1:0] PRE4_LAST   = 2'h3;
    localparam logic [7:0] PRE256_LAST = 8'hff;
    localparam logic [2:0] WD_FINAL    = 3'h7;

    // *****************************************************
    // register map and fields
    // *****************************************************
    localparam logic [1:0] OFS_CTRL   = 2'h0;
    localparam logic [1:0] OFS_STAT   = 2'h1;
    localparam int         CTRL_EN    = 0;
    localparam int         CTRL_POR   = 7;
    localparam int         STAT_CNT   = 0;
    localparam int         STAT_HALT  = 3;
    localparam int         STAT_WDRST = 4;

    // *****************************************************
    // reset-time load values
    // *****************************************************
    localparam logic [15:0] TIMER_INIT_VAL = 16'hfffc;
    localparam logic [15:0] SP_INIT_VAL    = 16'h00ff;
    localparam logic [15:0] VECTOR_ADDR    = 16'h3ffe;

    typedef enum logic [4:0] {
        ST_POR   = 5'h01,
        ST_RUN   = 5'h02,
        ST_WDRST = 5'h04,
        ST_STOP  = 5'h08,
        ST_EXT   = 5'h10
    } rcw_state_e;

endpackage : rcw_pkg

// ==== logic/rcw_watchdog_enable_bit_if.sv ====
// signals between the control logic and the watchdog counter
`timescale 1ns/1ps
`default_nettype none
interface rcw_watchdog_enable_bit_if;
    logic       tick;
    logic       clear;
    logic       run;
    logic       timeout;
    logic [2:0] count;
    modport ctl (output tick, output clear, output run, input timeout, input count);
    modport cnt (input tick, input clear, input run, output timeout, output count);
endinterface : rcw_watchdog_enable_bit_if
`default_nettype wire

// ==== logic/rcw_prescaler.sv ====
// divide-by-4 then divide-by-256 prescaler on the timer bit 7 carry
`timescale 1ns/1ps
`default_nettype none
module rcw_prescaler
    import rcw_pkg::*;
(
    input  wire logic clk,
    input  wire logic resetn,
    input  wire logic clear,
    input  wire logic carry7,
    output logic      tick
);
    logic [1:0] div4_reg;
    logic [7:0] div256_reg;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            div4_reg   <= 2'h0;
            div256_reg <= 8'h00;
            tick       <= 1'b0;
        end else if (clear) begin
            div4_reg   <= 2'h0;
            div256_reg <= 8'h00;
            tick       <= 1'b0;
        end else begin
            tick <= 1'b0;
            if (carry7) begin
                div4_reg <= div4_reg + 2'h1;
                if (div4_reg == PRE4_LAST) begin
                    div256_reg <= div256_reg + 8'h01;
                    tick       <= (div256_reg == PRE256_LAST);
                end
            end
        end
    end
endmodule : rcw_prescaler
`default_nettype wire

// ==== logic/rcw_watchdog_enable_bit_cnt.sv ====
// divide-by-7 watchdog counter
`timescale 1ns/1ps
`default_nettype none
module rcw_watchdog_enable_bit_cnt
    import rcw_pkg::*;
(
    input  wire logic clk,
    input  wire logic resetn,
    rcw_watchdog_enable_bit_if.cnt   wd
);
    logic [2:0] cnt_reg;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt_reg <= 3'h0;
        end else if (wd.clear || !wd.run) begin
            cnt_reg <= 3'h0;
        end else if (wd.tick && cnt_reg != WD_FINAL) begin
            cnt_reg <= cnt_reg + 3'h1;
        end
    end

    // final state reached after seven ticks from clear
    assign wd.timeout = wd.run && (cnt_reg == WD_FINAL);
    assign wd.count   = cnt_reg;
endmodule : rcw_watchdog_enable_bit_cnt
`default_nettype wire

// ==== testbench/rcw_pin_model.sv ====
// external reset circuitry: line pull-up plus a push-button pull-down
`timescale 1ns/1ps
`default_nettype none
module rcw_pin_model (
    input  wire logic dev_oe,
    input  wire logic dev_o,
    input  wire logic ext_low,
    output logic      pin
);
    // ***********************************************
    // wired line
    // ***********************************************
    // either pull-down wins over the pull-up; a released line reads high
    assign pin = !(ext_low || (dev_oe && !dev_o));
endmodule : rcw_pin_model
`default_nettype wire

// ==== testbench/rcw_reset_ctrl_test.sv ====
// self-checking bench for the reset pin and watchdog control
`timescale 1ns/1ps
`default_nettype none
module rcw_reset_ctrl_test;
    import rcw_pkg::*;
    logic        clk = 1'b0;
    logic        resetn = 1'b0;
    logic        ext_low = 1'b0;
    logic        carry = 1'b0;
    logic        stop_exec = 1'b0;
    logic        wait_enter = 1'b0;
    logic        wait_exit = 1'b0;
    logic [1:0]  reg_addr = 2'h0;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [7:0]  reg_rdata, d;
    logic [7:0]  rdata_halt, rdata_on;
    logic        pin, pin_o, pin_oe, core_reset, periph_init, imask_set, imask_clr;
    logic        osc_hold, clocks_clear, adc_disable;
    logic [15:0] timer_load, stack_init, vector;
    int          fails = 0;
    int          compares = 0;
    int          cycles = 0;
    int          n;

    always #25 clk = ~clk;

    rcw_pin_model far (.dev_oe(pin_oe), .dev_o(pin_o), .ext_low(ext_low), .pin(pin));

    rcw_reset_ctrl dut (
        .CLK(clk), .RESETN(resetn), .RESET_PIN_I(pin), .RESET_PIN_O(pin_o),
        .RESET_PIN_OE(pin_oe), .TIMER_CARRY7(carry), .STOP_EXEC(stop_exec),
        .WAIT_ENTER(wait_enter), .WAIT_EXIT(wait_exit), .REG_ADDR(reg_addr),
        .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
        .CORE_RESET(core_reset), .PERIPH_INIT(periph_init), .IMASK_SET(imask_set),
        .IMASK_CLR(imask_clr), .OSC_HOLD(osc_hold), .CLOCKS_CLEAR(clocks_clear),
        .ADC_DISABLE(adc_disable), .TIMER_LOAD_VAL(timer_load), .STACK_INIT(stack_init),
        .RESET_VECTOR(vector)
    );

    // same stimulus, other build options: halted in wait, watchdog on from reset
    rcw_reset_ctrl #(.WATCHDOG_ENABLE_BIT_OPT(1'b0), .WAIT_RUN_OPT(1'b0)) dut_halt (
        .CLK(clk), .RESETN(resetn), .RESET_PIN_I(pin), .RESET_PIN_O(), .RESET_PIN_OE(),
        .TIMER_CARRY7(carry), .STOP_EXEC(stop_exec), .WAIT_ENTER(wait_enter),
        .WAIT_EXIT(wait_exit), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr),
        .REG_RD(reg_rd), .REG_RDATA(rdata_halt), .CORE_RESET(), .PERIPH_INIT(), .IMASK_SET(),
        .IMASK_CLR(), .OSC_HOLD(), .CLOCKS_CLEAR(), .ADC_DISABLE(), .TIMER_LOAD_VAL(),
        .STACK_INIT(), .RESET_VECTOR()
    );

    rcw_reset_ctrl #(.WATCHDOG_ENABLE_BIT_OPT(1'b1), .WAIT_RUN_OPT(1'b1)) dut_on (
        .CLK(clk), .RESETN(resetn), .RESET_PIN_I(pin), .RESET_PIN_O(), .RESET_PIN_OE(),
        .TIMER_CARRY7(carry), .STOP_EXEC(stop_exec), .WAIT_ENTER(wait_enter),
        .WAIT_EXIT(wait_exit), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr),
        .REG_RD(reg_rd), .REG_RDATA(rdata_on), .CORE_RESET(), .PERIPH_INIT(), .IMASK_SET(),
        .IMASK_CLR(), .OSC_HOLD(), .CLOCKS_CLEAR(), .ADC_DISABLE(), .TIMER_LOAD_VAL(),
        .STACK_INIT(), .RESET_VECTOR()
    );

    // ***********************************************
    // helpers
    // ***********************************************
    task automatic tally_and_finish;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : tally_and_finish

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            fails++;
            tally_and_finish();
        end
    end

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [1:0] a, input logic [7:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [1:0] a, output logic [7:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        v = reg_rdata;
    endtask : rd

    // one-cycle pulse on {wait_exit, wait_enter, stop_exec}
    task automatic pulse(input logic [2:0] m);
        @(posedge clk);
        {wait_exit, wait_enter, stop_exec} <= m;
        @(posedge clk);
        {wait_exit, wait_enter, stop_exec} <= 3'h0;
    endtask : pulse

    function automatic logic pick(input int s);
        return (s == 0) ? pin_oe : (s == 1) ? core_reset : osc_hold;
    endfunction : pick

    task automatic waitv(input int s, input logic lvl, input int lim, output int k);
        for (k = 0; k < lim && pick(s) !== lvl; k++)
            @(negedge clk);
    endtask : waitv

    // timer bit 7 carries, one every two cycles; stops early once the pin is driven
    task automatic pump(input int cnt, output int seen);
        seen = -1;
        for (int i = 0; i < cnt && seen < 0; i++) begin
            @(posedge clk);
            carry <= 1'b1;
            @(posedge clk);
            carry <= 1'b0;
            if (pin_oe === 1'b1)
                seen = i;
        end
    endtask : pump

    // ***********************************************
    // tests
    // ***********************************************
    initial begin
        repeat (7) @(posedge clk);
        #1;
        chk("oe in power-on", 1'b1, pin_oe);
        chk("pin drive level", 1'b0, pin_o);
        chk("osc hold in power-on", 1'b1, osc_hold & clocks_clear);
        @(posedge clk);
        resetn <= 1'b1;
        waitv(0, 1'b0, 5000, n);
        chk("power-on hold length", 1'b1, n >= 4060 && n <= 4068);
        waitv(1, 1'b0, 20, n);
        chk("core reset after power-on", 1'b0, core_reset);
        chk("timer load", 16'hfffc, timer_load);
        chk("stack init", 16'h00ff, stack_init);
        chk("vector", 16'h3ffe, vector);
        rd(OFS_CTRL, d);
        chk("ctrl after power-on", {8'h00, 1'b1, 6'h00, 1'b0}, d);
        chk("ctrl with option on", 16'h0081, rdata_on);
        rd(2'h2, d);
        chk("unmapped read", 16'h0000, d);
        wr(OFS_CTRL, 8'h00);
        rd(OFS_CTRL, d);
        chk("ctrl after zero write", 16'h0000, d);
        // single-cycle glitch on the pin must be ignored
        @(posedge clk);
        ext_low <= 1'b1;
        @(posedge clk);
        ext_low <= 1'b0;
        repeat (6) @(negedge clk);
        chk("glitch ignored", 1'b0, core_reset);
        // shortest valid external reset: two cycles low
        @(posedge clk);
        ext_low <= 1'b1;
        repeat (2) @(posedge clk);
        ext_low <= 1'b0;
        waitv(1, 1'b1, 12, n);
        chk("external reset", 1'b1, core_reset);
        chk("init effects", 3'h7, {periph_init, imask_set, adc_disable});
        waitv(1, 1'b0, 12, n);
        chk("resume after pin high", 1'b0, core_reset);
        rd(OFS_CTRL, d);
        chk("flag kept clear", 16'h0000, d);
        pulse(3'b010);
        @(negedge clk);
        chk("wait clears mask", 1'b1, imask_clr);
        chk("wait keeps adc", 1'b0, adc_disable);
        pulse(3'b100);
        pulse(3'b001);
        @(negedge clk);
        chk("plain stop", 5'h0f, {pin_oe, osc_hold, clocks_clear, adc_disable, imask_clr});
        waitv(2, 1'b0, 5000, n);
        chk("stop hold length", 1'b1, n >= 4058 && n <= 4066);
        // watchdog enable, no disable, clear
        wr(OFS_CTRL, 8'h01);
        rd(OFS_CTRL, d);
        chk("enable", 16'h0001, d);
        wr(OFS_CTRL, 8'h00);
        rd(OFS_CTRL, d);
        chk("no disable", 16'h0001, d);
        pump(3584, n);
        rd(OFS_STAT, d);
        chk("count after 3.5 ticks", 3'h3, d[2:0]);
        wr(OFS_CTRL, 8'h01);
        rd(OFS_STAT, d);
        chk("count cleared", 3'h0, d[2:0]);
        pump(6144, n);
        rd(OFS_STAT, d);
        chk("count six", 3'h6, d[2:0]);
        chk("no timeout at six", 1'b0, pin_oe);
        pump(600, n);
        chk("seventh tick timeout", 1'b1, n >= 511 && n <= 513);
        waitv(0, 1'b0, 200, n);
        chk("pin hold length", 1'b1, n >= 20 && n <= 30);
        waitv(1, 1'b0, 20, n);
        chk("resume after timeout", 1'b0, core_reset);
        rd(OFS_STAT, d);
        chk("watchdog cause", 16'h0010, d);
        rd(OFS_CTRL, d);
        chk("enable from option", 16'h0000, d);
        // wait clears the counter, keeps the enable
        wr(OFS_CTRL, 8'h01);
        pump(2560, n);
        rd(OFS_STAT, d);
        chk("count two", 3'h2, d[2:0]);
        pulse(3'b010);
        rd(OFS_STAT, d);
        chk("wait clears count", 3'h0, d[2:0]);
        chk("halt in wait", 16'h0018, rdata_halt);
        rd(OFS_CTRL, d);
        chk("wait keeps enable", 16'h0001, d);
        pulse(3'b100);
        pulse(3'b001);
        waitv(0, 1'b1, 10, n);
        chk("stop with watchdog", 2'h2, {pin_oe, osc_hold});
        waitv(1, 1'b0, 200, n);
        chk("resume after stop reset", 1'b0, core_reset);
        tally_and_finish();
    end
endmodule : rcw_reset_ctrl_test
`default_nettype wire
